// [dpc_pkg.sv]
// shared constants and types for the pin command link
package dpc_pkg;
    // ============================================================
    // pin group widths
    localparam int BANKS = 4;
    localparam int BA_W = 2;
    localparam int ADDR_W = 13;
    localparam int COL_W = 10;
    localparam int DQ_W = 16;
    localparam int LANES = 2;
    localparam int LANE_W = 8;
    // ============================================================
    // address bit roles
    localparam int AP_BIT = 10;
    localparam int EMR1_DQSN_BIT = 10;
    localparam logic [1:0] BA_EMR1 = 2'h1;
    localparam logic DIFF_RST = 1'b1;
    // ============================================================
    // burst and local store shape
    localparam int BURST_LEN = 4;
    localparam int ROW_STORE_BITS = 2;
    localparam int COL_STORE_BITS = 4;
    // ============================================================
    // pin codes, ordered {cs_b, ras_b, cas_b, we_b}
    localparam logic [3:0] PIN_ACT = 4'h3;
    localparam logic [3:0] PIN_PRE = 4'h2;
    localparam logic [3:0] PIN_RD = 4'h5;
    localparam logic [3:0] PIN_WR = 4'h4;
    localparam logic [3:0] PIN_MRS = 4'h0;
    localparam logic [3:0] PIN_NOP = 4'h7;
    localparam logic [3:0] PIN_DESEL = 4'hF;
    // ============================================================
    // timing
    localparam int TRP_PS = 12500;
    localparam int LINK_PERIOD_PS = 15000;
    localparam int PRE_RAW = (TRP_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int PRE_CYCLES = (PRE_RAW < 1) ? 1 : PRE_RAW;
    localparam int RD_WAIT_CYCLES = 64;
    // ============================================================
    // controller request codes
    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_ACT = 3'h1,
        OP_PRE = 3'h2,
        OP_RD = 3'h3,
        OP_WR = 3'h4,
        OP_MRS = 3'h5
    } dpc_op_t;
endpackage

// [dpc_if.sv]
// pin bundle between controller end and memory end
`timescale 1ns/1ps
interface dpc_if;
    logic ck;
    logic ck_n;
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [dpc_pkg::BA_W-1:0] ba;
    logic [dpc_pkg::ADDR_W-1:0] a;
    logic [dpc_pkg::LANES-1:0] dm;
    logic [dpc_pkg::DQ_W-1:0] ctl_dq_o;
    logic ctl_dq_oe;
    logic [dpc_pkg::LANES-1:0] ctl_dqs_o;
    logic [dpc_pkg::LANES-1:0] ctl_dqs_n_o;
    logic ctl_dqs_oe;
    logic ctl_dqs_n_oe;
    logic [dpc_pkg::DQ_W-1:0] mem_dq_o;
    logic mem_dq_oe;
    logic [dpc_pkg::LANES-1:0] mem_dqs_o;
    logic [dpc_pkg::LANES-1:0] mem_dqs_n_o;
    logic mem_dqs_oe;
    logic mem_dqs_n_oe;
    logic [dpc_pkg::DQ_W-1:0] dq;
    logic [dpc_pkg::LANES-1:0] dqs;
    logic [dpc_pkg::LANES-1:0] dqs_n;
    // ============================================================
    // wire resolution, undriven dq and dqs read low, dqs_n reads high
    assign dq = mem_dq_oe ? mem_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
    assign dqs = mem_dqs_oe ? mem_dqs_o : (ctl_dqs_oe ? ctl_dqs_o : '0);
    assign dqs_n = mem_dqs_n_oe ? mem_dqs_n_o : (ctl_dqs_n_oe ? ctl_dqs_n_o : '1);
    modport ctl (
        output ck, ck_n, cs_b, ras_b, cas_b, we_b, ba, a, dm,
        output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_n_o, ctl_dqs_oe, ctl_dqs_n_oe,
        input dq, dqs, dqs_n
    );
    modport mem (
        input ck, ck_n, cs_b, ras_b, cas_b, we_b, ba, a, dm,
        output mem_dq_o, mem_dq_oe, mem_dqs_o, mem_dqs_n_o, mem_dqs_oe, mem_dqs_n_oe,
        input dq, dqs, dqs_n
    );
endinterface

// [dpc_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dpc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    // ============================================================
    // s1 feeds only s2; q moves once s2 and s3 agree
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < W; i++)
            begin
                if (s2_r[i] == s3_r[i])
                begin
                    q_r[i] <= s3_r[i];
                end
            end
        end
    end
    assign q = q_r;
endmodule // dpc_sync

// [dpc_mem_end.sv]
// memory end: command decode, bank state, strobed data store
`timescale 1ns/1ps
// Contract
// - row-open samples full row on A0-A12
// - column from A0-A9, A10 auto precharge
// - decoder acts only with chip select low
// - command pins taken at CK rise only
// - row-open opens addressed bank
// - precharge returns bank idle after completion
// - column access to addressed bank
// - WE# high read, low write
// - lower strobe bits 0-7, upper 8-15
// - EMR1 A10 selects differential strobes
// - writer drives strobes, reads edge-aligned
// - masked write bytes are discarded
// - each side releases data bus when idle
// - controller treats chip select as command
// - bank address picks one of four
module dpc_mem_end #(
    parameter int ROW_BITS = dpc_pkg::ROW_STORE_BITS,
    parameter int COL_BITS = dpc_pkg::COL_STORE_BITS,
    parameter int BURST = dpc_pkg::BURST_LEN,
    parameter int PRE_CYCLES = dpc_pkg::PRE_CYCLES
) (
    dpc_if.mem lnk,
    input wire logic rst_b,
    output logic [dpc_pkg::BANKS-1:0] bank_active,
    output logic strobe_diff,
    output logic burst_busy
);
    localparam int IDX_W = dpc_pkg::BA_W + ROW_BITS + COL_BITS;
    localparam int BEAT_W = $clog2(BURST + 1);
    localparam int PRE_W = $clog2(PRE_CYCLES + 1);
    // ============================================================
    // elaboration checks
    if (ROW_BITS < 1 || ROW_BITS > dpc_pkg::ADDR_W || COL_BITS < 1 || COL_BITS > dpc_pkg::COL_W)
    begin : g_bad_shape
        $error("store shape outside address pins");
    end
    if (BURST < 2 || (BURST % 2) != 0 || BURST > (1 << COL_BITS) || PRE_CYCLES < 1)
    begin : g_bad_burst
        $error("burst must be even and fit the column store");
    end

    logic [3:0] pins;
    logic is_act;
    logic is_pre;
    logic is_col;
    logic is_mrs;
    logic col_ok;
    logic ap_close;
    logic [dpc_pkg::BANKS-1:0] act_hit;
    logic [dpc_pkg::BANKS-1:0] pre_hit;
    logic [dpc_pkg::BANKS-1:0] active_r;
    logic [PRE_W-1:0] pre_cnt_r [dpc_pkg::BANKS];
    logic [dpc_pkg::ADDR_W-1:0] row_r [dpc_pkg::BANKS];
    logic [BEAT_W-1:0] remain_r;
    logic [BEAT_W-1:0] beat_r;
    logic is_wr_r;
    logic [dpc_pkg::BA_W-1:0] bank_r;
    logic [dpc_pkg::COL_W-1:0] col_r;
    logic ap_r;
    logic diff_r;
    logic [dpc_pkg::DQ_W-1:0] dq_o_r;
    logic dq_oe_r;
    logic dqs_r;
    logic [dpc_pkg::LANES-1:0] dqs_prev_r;
    logic [dpc_pkg::DQ_W-1:0] store [1 << IDX_W];

    function automatic logic [IDX_W-1:0] idx(
        input logic [dpc_pkg::BA_W-1:0] b,
        input logic [ROW_BITS-1:0] r,
        input logic [COL_BITS-1:0] c
    );
        return {b, r, c};
    endfunction

    // ============================================================
    // command decode
    // sampled at rise
    assign pins = {lnk.cs_b, lnk.ras_b, lnk.cas_b, lnk.we_b};
    assign is_act = (pins == dpc_pkg::PIN_ACT);
    assign is_pre = (pins == dpc_pkg::PIN_PRE);
    // cs low, ras high, cas low
    assign is_col = (pins == dpc_pkg::PIN_RD) || (pins == dpc_pkg::PIN_WR);
    assign is_mrs = (pins == dpc_pkg::PIN_MRS);
    // column commands to closed or closing banks are dropped
    assign col_ok = is_col && active_r[lnk.ba] && (pre_cnt_r[lnk.ba] == '0) && (remain_r == '0);
    assign ap_close = (remain_r == BEAT_W'(1)) && ap_r;

    always_comb
    begin
        for (int b = 0; b < dpc_pkg::BANKS; b++)
        begin
            act_hit[b] = is_act && (lnk.ba == dpc_pkg::BA_W'(b)) && !active_r[b];
            pre_hit[b] = (is_pre && active_r[b] && (lnk.a[dpc_pkg::AP_BIT] || lnk.ba == dpc_pkg::BA_W'(b)))
                || (ap_close && bank_r == dpc_pkg::BA_W'(b));
        end
    end

    // ============================================================
    // bank state
    // nop and refresh touch nothing
    always_ff @(posedge lnk.ck or negedge rst_b)
    begin
        if (!rst_b)
        begin
            active_r <= '0;
            for (int b = 0; b < dpc_pkg::BANKS; b++)
            begin
                pre_cnt_r[b] <= '0;
                row_r[b] <= '0;
            end
        end
        else
        begin
            for (int b = 0; b < dpc_pkg::BANKS; b++)
            begin
                if (pre_cnt_r[b] != '0)
                begin
                    pre_cnt_r[b] <= pre_cnt_r[b] - 1'b1;
                    if (pre_cnt_r[b] == PRE_W'(1))
                    begin
                        active_r[b] <= 1'b0;
                    end
                end
                else if (pre_hit[b])
                begin
                    pre_cnt_r[b] <= PRE_W'(PRE_CYCLES);
                end
                else if (act_hit[b])
                begin
                    active_r[b] <= 1'b1;
                    row_r[b] <= lnk.a;
                end
            end
        end
    end

    // ============================================================
    // burst sequencing
    always_ff @(posedge lnk.ck or negedge rst_b)
    begin
        if (!rst_b)
        begin
            remain_r <= '0;
            beat_r <= '0;
            is_wr_r <= 1'b0;
            bank_r <= '0;
            col_r <= '0;
            ap_r <= 1'b0;
        end
        else if (remain_r != '0)
        begin
            remain_r <= remain_r - 1'b1;
            beat_r <= beat_r + 1'b1;
        end
        else if (col_ok)
        begin
            remain_r <= BEAT_W'(BURST);
            beat_r <= '0;
            is_wr_r <= !lnk.we_b;
            bank_r <= lnk.ba;
            col_r <= lnk.a[dpc_pkg::COL_W-1:0];
            ap_r <= lnk.a[dpc_pkg::AP_BIT];
        end
    end

    // ============================================================
    // read drive
    always_ff @(posedge lnk.ck or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dq_o_r <= '0;
            dq_oe_r <= 1'b0;
            dqs_r <= 1'b0;
        end
        else if (col_ok && lnk.we_b)
        begin
            dq_o_r <= store[idx(lnk.ba, row_r[lnk.ba][ROW_BITS-1:0], lnk.a[COL_BITS-1:0])];
            dq_oe_r <= 1'b1;
            dqs_r <= 1'b1;
        end
        else if (remain_r > BEAT_W'(1) && !is_wr_r)
        begin
            dq_o_r <= store[idx(bank_r, row_r[bank_r][ROW_BITS-1:0],
                COL_BITS'(col_r[COL_BITS-1:0] + beat_r + 1'b1))];
            dqs_r <= ~dqs_r;
        end
        else if (remain_r == BEAT_W'(1))
        begin
            dq_oe_r <= 1'b0;
            dqs_r <= 1'b0;
        end
    end

    // ============================================================
    // strobe style, set through extended mode one
    always_ff @(posedge lnk.ck or negedge rst_b)
    begin
        if (!rst_b)
        begin
            diff_r <= dpc_pkg::DIFF_RST;
        end
        else if (is_mrs && lnk.ba == dpc_pkg::BA_EMR1)
        begin
            diff_r <= !lnk.a[dpc_pkg::EMR1_DQSN_BIT];
        end
    end

    // ============================================================
    // write capture, one byte per lane strobe edge
    always_ff @(posedge lnk.ck or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dqs_prev_r <= '0;
        end
        else
        begin
            dqs_prev_r <= lnk.dqs;
        end
    end

    // store has no reset; contents are undefined until written
    always_ff @(posedge lnk.ck)
    begin
        if (remain_r != '0 && is_wr_r)
        begin
            for (int l = 0; l < dpc_pkg::LANES; l++)
            begin
                if (lnk.dqs[l] != dqs_prev_r[l] && !lnk.dm[l])
                begin
                    store[idx(bank_r, row_r[bank_r][ROW_BITS-1:0],
                        COL_BITS'(col_r[COL_BITS-1:0] + beat_r))][l*dpc_pkg::LANE_W +: dpc_pkg::LANE_W]
                        <= lnk.dq[l*dpc_pkg::LANE_W +: dpc_pkg::LANE_W];
                end
            end
        end
    end

    // ============================================================
    // outputs
    assign lnk.mem_dq_o = dq_o_r;
    assign lnk.mem_dq_oe = dq_oe_r;
    assign lnk.mem_dqs_o = {dpc_pkg::LANES{dqs_r}};
    assign lnk.mem_dqs_oe = dq_oe_r;
    assign lnk.mem_dqs_n_o = {dpc_pkg::LANES{~dqs_r}};
    assign lnk.mem_dqs_n_oe = dq_oe_r && diff_r;
    assign bank_active = active_r;
    assign strobe_diff = diff_r;
    assign burst_busy = (remain_r != '0);
endmodule // dpc_mem_end

// [dpc_ctl_end.sv]
// controller end: link clock divider, command issue, burst data
`timescale 1ns/1ps
module dpc_ctl_end #(
    parameter int BURST = dpc_pkg::BURST_LEN,
    parameter int RD_WAIT = dpc_pkg::RD_WAIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    dpc_if.ctl lnk,
    input wire logic req_valid,
    output logic req_ready,
    input wire dpc_pkg::dpc_op_t req_op,
    input wire logic [dpc_pkg::BA_W-1:0] req_bank,
    input wire logic [dpc_pkg::ADDR_W-1:0] req_addr,
    input wire logic [BURST*dpc_pkg::DQ_W-1:0] req_wdata,
    input wire logic [BURST*dpc_pkg::LANES-1:0] req_wmask,
    output logic rsp_valid,
    output logic [BURST*dpc_pkg::DQ_W-1:0] rsp_rdata
);
    localparam int CNT_W = $clog2(BURST + 1);
    localparam int WAIT_W = $clog2(RD_WAIT + 1);
    localparam int SW = dpc_pkg::DQ_W + dpc_pkg::LANES;
    if (BURST < 2 || (BURST % 2) != 0 || RD_WAIT < 8)
    begin : g_bad_param
        $error("burst must be even, read wait at least 8");
    end

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CMD = 5'h02,
        ST_WR = 5'h04,
        ST_RD = 5'h08,
        ST_DONE = 5'h10
    } dpc_state_t;

    dpc_state_t state_r;
    dpc_pkg::dpc_op_t op_r;
    logic ck_r;
    logic fall;
    logic [3:0] pins_r;
    logic [dpc_pkg::BA_W-1:0] ba_r;
    logic [dpc_pkg::ADDR_W-1:0] a_r;
    logic [BURST*dpc_pkg::DQ_W-1:0] wdata_r;
    logic [BURST*dpc_pkg::LANES-1:0] wmask_r;
    logic [dpc_pkg::DQ_W-1:0] dq_o_r;
    logic [dpc_pkg::LANES-1:0] dm_r;
    logic dq_oe_r;
    logic dqs_r;
    logic diff_r;
    logic [CNT_W-1:0] beat_r;
    logic [CNT_W-1:0] cnt_r [dpc_pkg::LANES];
    logic [dpc_pkg::LANES-1:0] last_r;
    logic [WAIT_W-1:0] wait_r;
    logic rd_full;
    logic rsp_valid_r;
    logic [BURST*dpc_pkg::DQ_W-1:0] rdata_r;
    logic [SW-1:0] stab;

    // chip select is the top bit of every code
    // chip select in code
    function automatic logic [3:0] op_pins(input dpc_pkg::dpc_op_t op);
        case (op)
            dpc_pkg::OP_ACT: return dpc_pkg::PIN_ACT;
            dpc_pkg::OP_PRE: return dpc_pkg::PIN_PRE;
            dpc_pkg::OP_RD: return dpc_pkg::PIN_RD;
            dpc_pkg::OP_WR: return dpc_pkg::PIN_WR;
            dpc_pkg::OP_MRS: return dpc_pkg::PIN_MRS;
            default: return dpc_pkg::PIN_NOP;
        endcase
    endfunction

    // ============================================================
    // link clock, divide by two; pins move as ck falls
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ck_r <= 1'b0;
        end
        else
        begin
            ck_r <= ~ck_r;
        end
    end
    assign fall = ck_r;

    // ============================================================
    // sequencer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            op_r <= dpc_pkg::OP_NOP;
            pins_r <= dpc_pkg::PIN_DESEL;
            ba_r <= '0;
            a_r <= '0;
            wdata_r <= '0;
            wmask_r <= '0;
            dq_o_r <= '0;
            dm_r <= '0;
            dq_oe_r <= 1'b0;
            dqs_r <= 1'b0;
            diff_r <= dpc_pkg::DIFF_RST;
            beat_r <= '0;
            wait_r <= '0;
            rsp_valid_r <= 1'b0;
        end
        else
        begin
            rsp_valid_r <= 1'b0;
            if (fall && state_r != ST_CMD)
            begin
                pins_r <= dpc_pkg::PIN_DESEL;
            end
            case (state_r)
                ST_IDLE:
                begin
                    if (req_valid)
                    begin
                        op_r <= req_op;
                        ba_r <= req_bank;
                        a_r <= req_addr;
                        wdata_r <= req_wdata;
                        wmask_r <= req_wmask;
                        state_r <= ST_CMD;
                    end
                end
                ST_CMD:
                begin
                    if (fall)
                    begin
                        pins_r <= op_pins(op_r);
                        beat_r <= '0;
                        wait_r <= '0;
                        if (op_r == dpc_pkg::OP_MRS && ba_r == dpc_pkg::BA_EMR1)
                        begin
                            diff_r <= !a_r[dpc_pkg::EMR1_DQSN_BIT];
                        end
                        case (op_r)
                            dpc_pkg::OP_WR: state_r <= ST_WR;
                            dpc_pkg::OP_RD: state_r <= ST_RD;
                            default: state_r <= ST_DONE;
                        endcase
                    end
                end
                ST_WR:
                begin
                    if (fall && beat_r < CNT_W'(BURST))
                    begin
                        dq_o_r <= wdata_r[beat_r*dpc_pkg::DQ_W +: dpc_pkg::DQ_W];
                        dm_r <= wmask_r[beat_r*dpc_pkg::LANES +: dpc_pkg::LANES];
                        dq_oe_r <= 1'b1;
                        dqs_r <= ~dqs_r;
                        beat_r <= beat_r + 1'b1;
                    end
                    else if (fall)
                    begin
                        dq_oe_r <= 1'b0;
                        dqs_r <= 1'b0;
                        dm_r <= '0;
                        state_r <= ST_DONE;
                    end
                end
                ST_RD:
                begin
                    wait_r <= wait_r + 1'b1;
                    // a silent device ends the read after the wait
                    if (rd_full || wait_r == WAIT_W'(RD_WAIT))
                    begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    rsp_valid_r <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // read capture through the pin synchroniser
    dpc_sync #(.W(SW)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d({lnk.dqs, lnk.dq}),
        .q(stab)
    );

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            last_r <= '0;
            rdata_r <= '0;
            for (int l = 0; l < dpc_pkg::LANES; l++)
            begin
                cnt_r[l] <= '0;
            end
        end
        else if (state_r == ST_CMD)
        begin
            last_r <= '0;
            for (int l = 0; l < dpc_pkg::LANES; l++)
            begin
                cnt_r[l] <= '0;
            end
        end
        else if (state_r == ST_RD)
        begin
            for (int l = 0; l < dpc_pkg::LANES; l++)
            begin
                if (stab[dpc_pkg::DQ_W+l] != last_r[l] && cnt_r[l] < CNT_W'(BURST))
                begin
                    rdata_r[cnt_r[l]*dpc_pkg::DQ_W + l*dpc_pkg::LANE_W +: dpc_pkg::LANE_W]
                        <= stab[l*dpc_pkg::LANE_W +: dpc_pkg::LANE_W];
                    cnt_r[l] <= cnt_r[l] + 1'b1;
                    last_r[l] <= stab[dpc_pkg::DQ_W+l];
                end
            end
        end
    end

    always_comb
    begin
        rd_full = 1'b1;
        for (int l = 0; l < dpc_pkg::LANES; l++)
        begin
            rd_full = rd_full && (cnt_r[l] == CNT_W'(BURST));
        end
    end

    // ============================================================
    // outputs
    assign lnk.ck = ck_r;
    assign lnk.ck_n = ~ck_r;
    assign {lnk.cs_b, lnk.ras_b, lnk.cas_b, lnk.we_b} = pins_r;
    assign lnk.ba = ba_r;
    assign lnk.a = a_r;
    assign lnk.dm = dm_r;
    assign lnk.ctl_dq_o = dq_o_r;
    assign lnk.ctl_dq_oe = dq_oe_r;
    assign lnk.ctl_dqs_o = {dpc_pkg::LANES{dqs_r}};
    assign lnk.ctl_dqs_n_o = {dpc_pkg::LANES{~dqs_r}};
    assign lnk.ctl_dqs_oe = dq_oe_r;
    assign lnk.ctl_dqs_n_oe = dq_oe_r && diff_r;
    assign req_ready = (state_r == ST_IDLE);
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rdata_r;
endmodule // dpc_ctl_end

// [dpc_link_props.sv]
// pin link assertions
`timescale 1ns/1ps
module dpc_link_props (
    input wire logic ck,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic mem_dq_oe,
    input wire logic ctl_dq_oe,
    input wire logic mem_dqs_oe,
    input wire logic mem_dqs_n_oe,
    input wire logic [1:0] mem_dqs_o,
    input wire logic [1:0] mem_dqs_n_o
);
    default clocking @(posedge ck); endclocking
    default disable iff (!rst_b);
    logic [3:0] cmd;
    assign cmd = {cs_b, ras_b, cas_b, we_b};
    // ============================================================
    // burst shapes, four beats then release
    sequence rd_beats;
        mem_dq_oe [*4] ##1 !mem_dq_oe;
    endsequence
    sequence wr_beats;
        ctl_dq_oe [*4] ##1 !ctl_dq_oe;
    endsequence
    // ============================================================
    // checks
    one_driver_a: assert property (!(mem_dq_oe && ctl_dq_oe))
        else $error("data bus driven by both ends");
    rd_start_a: assert property ($rose(mem_dq_oe) |-> $past(cmd) == dpc_pkg::PIN_RD)
        else $error("read drive without read command");
    burst_len_a: assert property ($rose(mem_dq_oe) |-> rd_beats)
        else $error("read burst length wrong");
    wr_burst_a: assert property (cmd == dpc_pkg::PIN_WR |=> wr_beats)
        else $error("write burst length wrong");
    desel_quiet_a: assert property (cs_b |=> !$rose(mem_dq_oe))
        else $error("deselected command acted on");
    strobe_first_a: assert property ($rose(mem_dq_oe) |-> mem_dqs_o == 2'h3)
        else $error("read strobes not high on first beat");
    strobe_toggle_a: assert property (mem_dq_oe && $past(mem_dq_oe) |-> mem_dqs_o == ~$past(mem_dqs_o))
        else $error("read strobe not toggling");
    diff_pair_a: assert property (mem_dqs_n_oe |-> mem_dqs_oe && mem_dqs_n_o == ~mem_dqs_o)
        else $error("complement strobe wrong");
endmodule // dpc_link_props

// [ddr2_pin_command_decode_tb.sv]
// bench for both link ends
`timescale 1ns/1ps
module ddr2_pin_command_decode_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b1;
    logic req_valid = 1'b0;
    logic req_ready;
    dpc_pkg::dpc_op_t req_op = dpc_pkg::OP_NOP;
    logic [1:0] req_bank = 2'h0;
    logic [12:0] req_addr = 13'h0;
    logic [63:0] req_wdata = 64'h0;
    logic [7:0] req_wmask = 8'h0;
    logic rsp_valid;
    logic [63:0] rsp_rdata;
    logic [3:0] bank_active;
    logic strobe_diff;
    logic burst_busy;
    int n_errors = 0;
    int check_count = 0;
    dpc_if lnk_if();
    dpc_ctl_end dpc_ctl_end_inst (.clk, .rst_b, .lnk(lnk_if), .req_valid, .req_ready, .req_op, .req_bank,
        .req_addr, .req_wdata, .req_wmask, .rsp_valid, .rsp_rdata);
    dpc_mem_end dpc_mem_end_inst (.lnk(lnk_if), .rst_b, .bank_active, .strobe_diff, .burst_busy);
    dpc_link_props dpc_link_props_inst (.ck(lnk_if.ck), .rst_b, .cs_b(lnk_if.cs_b), .ras_b(lnk_if.ras_b),
        .cas_b(lnk_if.cas_b), .we_b(lnk_if.we_b), .mem_dq_oe(lnk_if.mem_dq_oe), .ctl_dq_oe(lnk_if.ctl_dq_oe),
        .mem_dqs_oe(lnk_if.mem_dqs_oe), .mem_dqs_n_oe(lnk_if.mem_dqs_n_oe), .mem_dqs_o(lnk_if.mem_dqs_o),
        .mem_dqs_n_o(lnk_if.mem_dqs_n_o));
    always #10 clk = ~clk;
    // ============================================================
    // shared tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // waits settle the slower link domain
    task automatic op(input dpc_pkg::dpc_op_t o, input logic [1:0] b, input logic [12:0] ad,
        input logic [63:0] wd, input logic [7:0] wm);
        while (req_ready !== 1'b1) @(negedge clk);
        req_valid = 1'b1;
        {req_op, req_bank, req_addr, req_wdata, req_wmask} = {o, b, ad, wd, wm};
        @(negedge clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge clk);
        repeat (4) @(negedge clk);
    endtask
    task automatic complete_run;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ============================================================
    // scenarios
    task automatic s_strobe(input logic v);
        op(dpc_pkg::OP_MRS, 2'h1, {2'h0, v, 10'h0}, 64'h0, 8'h0);
        chk(strobe_diff, !v);
    endtask
    task automatic s_open;
        op(dpc_pkg::OP_ACT, 2'h1, 13'h1FFF, 64'h0, 8'h0);
        chk(bank_active, 64'h2);
        op(dpc_pkg::OP_NOP, 2'h2, 13'h0, 64'h0, 8'h0);
        chk(bank_active, 64'h2);
    endtask
    // upper address bits must not move the column
    task automatic s_mask;
        op(dpc_pkg::OP_WR, 2'h1, 13'h0004, 64'h1111_2222_3333_4444, 8'h00);
        op(dpc_pkg::OP_WR, 2'h1, 13'h0804, 64'hAAAA_BBBB_CCCC_DDDD, 8'h24);
        op(dpc_pkg::OP_RD, 2'h1, 13'h1804, 64'h0, 8'h0);
        chk(rsp_rdata, 64'hAAAA_22BB_CC33_DDDD);
        chk(bank_active, 64'h2);
        chk(burst_busy, 64'h0);
    endtask
    task automatic s_close;
        op(dpc_pkg::OP_PRE, 2'h1, 13'h0, 64'h0, 8'h0);
        chk(bank_active, 64'h0);
    endtask
    task automatic s_autopre;
        op(dpc_pkg::OP_ACT, 2'h2, 13'h0003, 64'h0, 8'h0);
        chk(bank_active, 64'h4);
        op(dpc_pkg::OP_RD, 2'h2, 13'h0400, 64'h0, 8'h0);
        chk(bank_active, 64'h0);
    endtask
    // mid-run reset closes banks and restores strobe style
    task automatic s_reset;
        op(dpc_pkg::OP_ACT, 2'h3, 13'h0001, 64'h0, 8'h0);
        chk(bank_active, 64'h8);
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        chk(bank_active, 64'h0);
        chk(strobe_diff, 64'h1);
        chk(req_ready, 64'h1);
        rst_b = 1'b1;
        op(dpc_pkg::OP_ACT, 2'h3, 13'h0002, 64'h0, 8'h0);
        chk(bank_active, 64'h8);
        op(dpc_pkg::OP_PRE, 2'h0, 13'h0400, 64'h0, 8'h0);
        chk(bank_active, 64'h0);
    endtask
    // ============================================================
    // main sequence and watchdog
    initial
    begin
        // link clock stands still in reset, so the memory end needs a falling reset edge
        @(negedge clk);
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        s_strobe(1'b1);
        s_open();
        s_mask();
        s_close();
        s_reset();
        s_strobe(1'b0);
        s_autopre();
        complete_run();
    end
    initial
    begin
        #200000;
        n_errors++;
        complete_run();
    end
endmodule // ddr2_pin_command_decode_tb
